/* File: rtl/reset_sequencer.v */
// Purpose : Sorts reset requests and runs the internal reset sequence.
// Assumes : 10 MHz core clock, the CPU clock; pins are asynchronous.
// Notes   : All durations come from one counter in core clock cycles.
// Notes on behaviour
// - long reset start enters default state at once
// - reset input low beyond 1040 half-clocks is a long hardware reset
// - power-down pin low during pulse means async, high means sync
// - power-down low while reset low cancels pull-down, ends async
// - reset input low two clocks is detected; then tristate, output low
// - within 12 half-clocks cancel holds and abort external cycle
// - bidirectional enable pulls input low in sequence; cleared every reset
// - sequence lasts 1024 half-clocks, then release and sample input
// - on exit, power-down level picks async or sync completion
// - latch config 8 half-clocks after rise, 6 when bypassed; idle strobes
// - execution starts from address zero in segment zero
// - pulse up to 1038 half-clocks with pin high is short reset
// - input still low at sequence end extends into long reset
// - software reset starts the sequence like a short reset
// - soft resets latch config bits 12..6 and clear 5..2
// - watchdog overflow triggers the reset sequence
// - watchdog finishes or aborts running bus cycle by ready
// - async reset acts combinationally, no clock needed
// - reset output stays low until end of initialisation
`timescale 1ns/100ps
`include "reset_seq_defs.vh"
module reset_sequencer (
    input  wire        CORE_CLK_I,        // Core clock, 10 MHz
    input  wire        RST_N_I,           // Power-on reset, active low
    input  wire        RESET_IN_N_I,      // Reset input pin level
    input  wire        POWERDOWN_LEVEL_I, // Power-down pin threshold
    input  wire        READY_N_I,         // Bus ready pin, active low
    input  wire [15:0] BOOT_CONFIG_I,     // Config port pin levels
    input  wire        SW_RESET_I,        // Software reset executed
    input  wire        WDT_OVERFLOW_I,    // Watchdog overflow pulse
    input  wire        END_INIT_I,        // End of init executed
    input  wire        SYSCFG_WR_I,       // Config register write
    input  wire [15:0] SYSCFG_DATA_I,     // Config register data
    input  wire        BUS_ACTIVE_I,      // External cycle running
    input  wire        BUS_USES_READY_I,  // Cycle samples ready
    input  wire        BUS_WAITS_DONE_I,  // Wait states elapsed
    input  wire        PLL_BYPASS_I,      // PLL bypassed, prescaler on
    output reg         RESET_OUT_N_O,     // Reset output pin
    output reg         RESET_IN_N_O,      // Reset pin drive value
    output reg         RESET_IN_N_OE_O,   // Reset pin pull-down enable
    output reg         BUS_TRISTATE_O,    // Bus and I/O drivers off
    output reg         CFG_PULLUP_O,      // Config port pulled high
    output reg         HOLD_CANCEL_O,     // Cancel hold states pulse
    output reg         BUS_ABORT_O,       // Abort external cycle pulse
    output reg         STROBE_IDLE_O,     // Fetch strobes inactive
    output reg         CPU_START_O,       // Start execution pulse
    output reg  [23:0] START_ADDR_O,      // First fetch address
    output wire [15:0] BOOT_CFG_O,        // Latched configuration
    output reg  [1:0]  RESET_KIND_O,      // Kind of last reset
    output reg         ASYNC_MODE_O,      // Reset handled async
    output reg         BIDIR_ENABLE_O     // Bidirectional reset bit
);

    // ==========================================================
    // States and storage
    // ==========================================================
    localparam [7:0] S_RUN   = 8'h01;
    localparam [7:0] S_DET   = 8'h02;
    localparam [7:0] S_SYNC  = 8'h04;
    localparam [7:0] S_SEQ   = 8'h08;
    localparam [7:0] S_REL   = 8'h10;
    localparam [7:0] S_EXT   = 8'h20;
    localparam [7:0] S_LATCH = 8'h40;
    localparam [7:0] S_WDW   = 8'h80;

    reg  [7:0]  state;
    reg  [7:0]  next_state;
    reg  [10:0] cnt;
    reg  [10:0] next_cnt;
    reg  [1:0]  kind;
    reg  [1:0]  next_kind;
    reg         async_mode;
    reg         next_async;
    reg         bidir;
    reg         next_bidir;
    reg         init_pending;
    reg         next_init;
    reg         next_cancel;
    reg         next_abort;
    reg         next_load;
    reg  [10:0] latch_lim;
    wire        rin_n;
    wire        pd_level;
    wire        ready_n;
    wire [15:0] cfg_pins;
    wire        rst_core_n;
    wire        in_reset;

    // ==========================================================
    // Asynchronous reset path
    // ==========================================================
    // combinational async reset
    // Pin and power-down low reset all state without a clock,
    // so power-on works before the clock runs.
    assign rst_core_n = RST_N_I & (RESET_IN_N_I | POWERDOWN_LEVEL_I);

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    // synchronised ready, power-down and reset pin levels
    pin_sync #(
        .W    (3),
        .INIT (`PIN_RST)
    ) u_ctl_sync (
        .clk_i   (CORE_CLK_I),
        .rst_n_i (rst_core_n),
        .pin_i   ({READY_N_I, POWERDOWN_LEVEL_I, RESET_IN_N_I}),
        .level_o ({ready_n, pd_level, rin_n})
    );

    // Config port is static in reset; skew harmless
    pin_sync #(
        .W    (16),
        .INIT (`CFG_PIN_RST)
    ) u_cfg_sync (
        .clk_i   (CORE_CLK_I),
        .rst_n_i (rst_core_n),
        .pin_i   (BOOT_CONFIG_I),
        .level_o (cfg_pins)
    );

    // ==========================================================
    // Configuration latch
    // ==========================================================
    boot_cfg_latch u_cfg (
        .clk_i   (CORE_CLK_I),
        .rst_n_i (rst_core_n),
        .load_i  (next_load),
        .kind_i  (kind),
        .data_i  (cfg_pins),
        .cfg_o   (BOOT_CFG_O)
    );

    assign in_reset = (state != S_RUN) && (state != S_WDW);

    // ==========================================================
    // Sequencer next-state logic
    // ==========================================================
    // Latch delay after the rising edge depends on the clock mode
    always @* begin
        latch_lim = PLL_BYPASS_I ? `LATCH_BYP_CYC : `LATCH_CYC;
    end

    always @* begin
        next_state  = state;
        next_cnt    = cnt + 11'd1;
        next_kind   = kind;
        next_async  = async_mode;
        next_bidir  = bidir;
        next_init   = init_pending;
        next_cancel = 1'b0;
        next_abort  = 1'b0;
        next_load   = 1'b0;
        case (state)
            S_RUN: begin
                next_cnt = 11'd0;
                if (!rin_n) begin
                    next_state = S_DET;
                end else if (SW_RESET_I) begin
                    next_state  = S_SEQ;
                    next_kind   = `KIND_SOFT;
                    next_async  = 1'b0;
                    next_cancel = 1'b1;
                    next_abort  = 1'b1;
                end else if (WDT_OVERFLOW_I) begin
                    next_state  = S_WDW;
                    next_kind   = `KIND_SOFT;
                    next_async  = 1'b0;
                    next_cancel = 1'b1;
                end
                if (END_INIT_I) begin
                    next_init = 1'b0;
                end
                if (SYSCFG_WR_I && init_pending) begin
                    next_bidir = SYSCFG_DATA_I[`BIDIR_BIT];
                end
            end
            S_WDW: begin
                if (!rin_n) begin
                    next_state = S_DET;
                    next_cnt   = 11'd0;
                end else if (!BUS_ACTIVE_I) begin
                    next_state  = S_SEQ;
                    next_cnt    = 11'd0;
                    next_cancel = 1'b1;
                end else if (BUS_USES_READY_I && BUS_WAITS_DONE_I &&
                             ready_n) begin
                    next_state  = S_SEQ;
                    next_cnt    = 11'd0;
                    next_cancel = 1'b1;
                    next_abort = 1'b1;
                end
            end
            S_DET: begin
                if (rin_n) begin
                    next_state = S_RUN;
                end else if (cnt == `DETECT_CYC - 11'd2) begin
                    next_state  = S_SYNC;
                    next_cnt    = 11'd0;
                    next_kind   = `KIND_SHORT;
                    next_async  = ~pd_level;
                    next_cancel = 1'b1;
                    next_abort  = 1'b1;
                end
            end
            S_SYNC: begin
                if (cnt == `SYNC_CYC - 11'd1) begin
                    next_state = S_SEQ;
                    next_cnt   = 11'd0;
                end
            end
            S_SEQ: begin
                if (cnt == `SEQ_CYC - 11'd1) begin
                    next_state = S_REL;
                    next_cnt   = 11'd0;
                    next_bidir = 1'b0;
                end
            end
            S_REL: begin
                // Own pull-down must drain through the synchroniser first
                if (cnt == `PIN_LAT_CYC - 11'd1) begin
                    next_cnt = 11'd0;
                    if (!rin_n) begin
                        next_state = S_EXT;
                        next_kind  = `KIND_LONG;
                    end else begin
                        next_state = S_LATCH;
                        next_async = ~pd_level;
                    end
                end
            end
            S_EXT: begin
                next_cnt = 11'd0;
                if (rin_n) begin
                    next_state = S_LATCH;
                    next_async = ~pd_level;
                end
            end
            S_LATCH: begin
                if (cnt == latch_lim - 11'd1) begin
                    next_state = S_RUN;
                    next_cnt   = 11'd0;
                    next_load  = 1'b1;
                end
            end
            default: begin
                next_state = S_SEQ;
                next_cnt   = 11'd0;
            end
        endcase
        if ((next_state != S_RUN) && (state != S_RUN) && !rin_n &&
            !pd_level) begin
            next_async = 1'b1;
            next_bidir = 1'b0;
        end
        // hold reset output until init ends
        if (next_state != S_RUN && next_state != S_WDW) begin
            next_init = 1'b1;
        end
    end

    // ==========================================================
    // State registers
    // ==========================================================
    // reset default state
    // Long async reset values, imposed at once
    always @(posedge CORE_CLK_I or negedge rst_core_n) begin
        if (!rst_core_n) begin
            state        <= S_SEQ;
            cnt          <= 11'd0;
            kind         <= `KIND_LONG;
            async_mode   <= 1'b1;
            bidir        <= 1'b0;
            init_pending <= 1'b1;
        end else begin
            state        <= next_state;
            cnt          <= next_cnt;
            kind         <= next_kind;
            async_mode   <= next_async;
            bidir        <= next_bidir;
            init_pending <= next_init;
        end
    end

    // ==========================================================
    // Registered outputs
    // ==========================================================
    // Outputs follow the next state
    always @(posedge CORE_CLK_I or negedge rst_core_n) begin
        if (!rst_core_n) begin
            RESET_OUT_N_O   <= 1'b0;
            RESET_IN_N_O    <= 1'b0;
            RESET_IN_N_OE_O <= 1'b0;
            BUS_TRISTATE_O  <= 1'b1;
            CFG_PULLUP_O    <= 1'b1;
            HOLD_CANCEL_O   <= 1'b1;
            BUS_ABORT_O     <= 1'b1;
            STROBE_IDLE_O   <= 1'b0;
            CPU_START_O     <= 1'b0;
            START_ADDR_O    <= `START_ADDR;
            RESET_KIND_O    <= `KIND_LONG;
            ASYNC_MODE_O    <= 1'b1;
            BIDIR_ENABLE_O  <= 1'b0;
        end else begin
            RESET_OUT_N_O   <= (next_state == S_RUN) && !next_init;
            RESET_IN_N_O    <= 1'b0;
            RESET_IN_N_OE_O <= (next_state == S_SEQ) && next_bidir;
            BUS_TRISTATE_O  <= (next_state != S_RUN) &&
                               (next_state != S_DET) &&
                               (next_state != S_WDW) &&
                               (next_state != S_LATCH);
            CFG_PULLUP_O    <= (next_state != S_RUN) &&
                               (next_state != S_DET) &&
                               (next_state != S_WDW);
            HOLD_CANCEL_O   <= next_cancel;
            BUS_ABORT_O     <= next_abort;
            STROBE_IDLE_O   <= (next_state == S_LATCH);
            CPU_START_O     <= next_load;
            START_ADDR_O    <= `START_ADDR;
            RESET_KIND_O    <= next_kind;
            ASYNC_MODE_O    <= next_async;
            BIDIR_ENABLE_O  <= next_bidir;
        end
    end

    // Reset-state decode, spare
    wire unused_in_reset;
    assign unused_in_reset = in_reset;

endmodule // reset_sequencer

/* File: rtl/reset_seq_defs.vh */
// Purpose : Constants for the reset sequencer and its helpers.
// Assumes : Core clock is the CPU clock; one period is two half-clock units.
// Notes   : Times in half-clock units; cycles derive from them, except PIN_LAT_CYC, given in cycles.
`ifndef RESET_SEQ_DEFS_VH
`define RESET_SEQ_DEFS_VH

// ==========================================================
// Timing in half-clock units and derived cycle counts
// ==========================================================
`define TCL_PER_CLK     11'd2
`define DETECT_TCL      11'd4
`define SYNC_TCL        11'd12
`define SEQ_TCL         11'd1024
`define LATCH_TCL       11'd8
`define LATCH_BYP_TCL   11'd6
`define LONG_TCL        11'd1040
`define SHORT_MAX_TCL   11'd1038
`define DETECT_CYC      (`DETECT_TCL / `TCL_PER_CLK)
`define SYNC_CYC        (`SYNC_TCL / `TCL_PER_CLK)
`define SEQ_CYC         (`SEQ_TCL / `TCL_PER_CLK)
`define LATCH_CYC       (`LATCH_TCL / `TCL_PER_CLK)
`define LATCH_BYP_CYC   (`LATCH_BYP_TCL / `TCL_PER_CLK)
// Sync plus filter take four edges; one more before sampling
`define PIN_LAT_CYC     11'd5

// ==========================================================
// Fields, kinds and reset values
// ==========================================================
`define BIDIR_BIT       3
`define KIND_LONG       2'd0
`define KIND_SHORT      2'd1
`define KIND_SOFT       2'd2
`define CFG_MASK_LONG   16'hffff
`define CFG_MASK_SHORT  16'h1fff
`define CFG_MASK_SOFT   16'h1fc0
`define CFG_CLR_SOFT    16'h003c
`define CFG_RST         16'h0000
`define CFG_PIN_RST     16'hffff
`define START_ADDR      24'h000000
`define PIN_RST         3'b100

`endif

/* File: rtl/pin_sync.v */
// Purpose : Three-stage synchroniser with agreement filter per pin.
// Assumes : Pins are asynchronous to the core clock.
// Notes   : A change counts only when stages two and three agree.
`timescale 1ns/100ps
module pin_sync #(
    parameter         W    = 1,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    input  wire         clk_i,   // Core clock
    input  wire         rst_n_i, // Async reset, active low
    input  wire [W-1:0] pin_i,   // Raw pin levels
    output reg  [W-1:0] level_o  // Filtered levels
);

    reg [W-1:0] s1;
    reg [W-1:0] s2;
    reg [W-1:0] s3;

    // ==========================================================
    // Stages and filter, one per pin
    // ==========================================================
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            // Stage one feeds only stage two
            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    s1[g]      <= INIT[g];
                    s2[g]      <= INIT[g];
                    s3[g]      <= INIT[g];
                    level_o[g] <= INIT[g];
                end else begin
                    s1[g] <= pin_i[g];
                    s2[g] <= s1[g];
                    s3[g] <= s2[g];
                    if (s2[g] == s3[g]) begin
                        level_o[g] <= s3[g];
                    end
                end
            end
        end
    endgenerate

endmodule // pin_sync

/* File: rtl/boot_cfg_latch.v */
// Purpose : Holds the boot configuration taken from the config port.
// Assumes : Load is a one-cycle pulse from the sequencer.
// Notes   : Bits taken depend on reset kind.
`timescale 1ns/100ps
`include "reset_seq_defs.vh"
module boot_cfg_latch (
    input  wire        clk_i,   // Core clock
    input  wire        rst_n_i, // Async reset, active low
    input  wire        load_i,  // Latch pulse
    input  wire [1:0]  kind_i,  // Reset kind
    input  wire [15:0] data_i,  // Synchronised port levels
    output reg  [15:0] cfg_o    // Latched configuration
);

    // ==========================================================
    // Masked latch
    // ==========================================================
    // partial soft latch
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_o <= `CFG_RST;
        end else if (load_i) begin
            case (kind_i)
                `KIND_LONG: begin
                    cfg_o <= data_i & `CFG_MASK_LONG;
                end
                `KIND_SHORT: begin
                    cfg_o <= (cfg_o & ~`CFG_MASK_SHORT) |
                             (data_i & `CFG_MASK_SHORT);
                end
                default: begin
                    cfg_o <= ((cfg_o & ~`CFG_MASK_SOFT) |
                              (data_i & `CFG_MASK_SOFT)) & ~`CFG_CLR_SOFT;
                end
            endcase
        end
    end

endmodule // boot_cfg_latch

/* File: verification/reset_sequencer_props.sv */
// Purpose : Port timing checks.
// Assumes : One core clock.
// Notes   : Windows allow for pin synchronisers.
`timescale 1ns/100ps
// ==========================================================
// Checker
// ==========================================================
module reset_sequencer_props (
    input wire logic        CORE_CLK_I,        // Clock
    input wire logic        RST_N_I,           // Power-on reset
    input wire logic        RESET_IN_N_I,      // Reset pin
    input wire logic        POWERDOWN_LEVEL_I, // Power-down level
    input wire logic        END_INIT_I,        // End of init
    input wire logic        PLL_BYPASS_I,      // Short latch wait
    input wire logic        RESET_OUT_N_O,     // Reset output
    input wire logic        RESET_IN_N_OE_O,   // Pin pull-down
    input wire logic        BUS_TRISTATE_O,    // Drivers off
    input wire logic        CFG_PULLUP_O,      // Port pulled high
    input wire logic        HOLD_CANCEL_O,     // Cancel pulse
    input wire logic        STROBE_IDLE_O,     // Latch wait
    input wire logic        CPU_START_O,       // Start pulse
    input wire logic [23:0] START_ADDR_O,      // First address
    input wire logic        ASYNC_MODE_O,      // Async handling
    input wire logic        BIDIR_ENABLE_O     // Bidir bit
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);
    logic       init_done; // Init ended
    logic [9:0] oe_cnt;    // Pull length
    // Init seen, pull length
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            init_done <= 1'b0;
            oe_cnt    <= 10'h000;
        end else begin
            init_done <= !CPU_START_O && (init_done || END_INIT_I);
            oe_cnt    <= RESET_IN_N_OE_O ? oe_cnt + 10'h001 : 10'h000;
        end
    end
    sequence s_pin_held;
        $fell(RESET_IN_N_I) ##0 (!RESET_IN_N_I) [*6];
    endsequence
    sequence s_glitch;
        RESET_OUT_N_O && $past(RESET_IN_N_I, 2) && $rose(RESET_IN_N_I);
    endsequence
    chk_async_state: assert property (
        !RESET_IN_N_I && !POWERDOWN_LEVEL_I |-> !RESET_OUT_N_O
        && BUS_TRISTATE_O && CFG_PULLUP_O && !CPU_START_O)
        else $error("async state wrong");
    chk_pd_cancel: assert property (
        !RESET_IN_N_I && !POWERDOWN_LEVEL_I |-> !RESET_IN_N_OE_O
        && ASYNC_MODE_O && !BIDIR_ENABLE_O)
        else $error("pd cancel missed");
    chk_detect_low: assert property (
        s_pin_held |-> ##[0:4] (!RESET_OUT_N_O && BUS_TRISTATE_O))
        else $error("no detect");
    chk_glitch_ignored: assert property (
        s_glitch |-> RESET_OUT_N_O [*8])
        else $error("glitch taken");
    chk_cancel_soon: assert property (
        $rose(BUS_TRISTATE_O) |-> ##[0:6] HOLD_CANCEL_O)
        else $error("cancel late");
    chk_pull_len: assert property (
        $fell(RESET_IN_N_OE_O) && POWERDOWN_LEVEL_I
        |-> oe_cnt >= 10'd510 && oe_cnt <= 10'd520)
        else $error("pull length");
    chk_latch_full: assert property (
        $rose(STROBE_IDLE_O) && !PLL_BYPASS_I |-> ##[3:5] CPU_START_O)
        else $error("latch wait");
    chk_latch_byp: assert property (
        $rose(STROBE_IDLE_O) && PLL_BYPASS_I |-> ##[2:4] CPU_START_O)
        else $error("bypass wait");
    chk_start_addr: assert property (
        CPU_START_O |-> START_ADDR_O == 24'h000000)
        else $error("start addr");
    chk_reset_out_n_end_of_init_instr: assert property (
        $rose(RESET_OUT_N_O) |-> init_done)
        else $error("early release");
    chk_bidir_clear: assert property (
        CPU_START_O |-> !BIDIR_ENABLE_O && !RESET_IN_N_OE_O)
        else $error("bidir left");
endmodule // reset_sequencer_props
bind reset_sequencer reset_sequencer_props u_props (.CORE_CLK_I,
    .RST_N_I, .RESET_IN_N_I, .POWERDOWN_LEVEL_I, .END_INIT_I,
    .PLL_BYPASS_I, .RESET_OUT_N_O, .RESET_IN_N_OE_O, .BUS_TRISTATE_O,
    .CFG_PULLUP_O, .HOLD_CANCEL_O, .STROBE_IDLE_O, .CPU_START_O,
    .START_ADDR_O, .ASYNC_MODE_O, .BIDIR_ENABLE_O);

/* File: verification/reset_board.sv */
// Purpose : Board reset circuit and bus slave.
// Assumes : Reset pin has a pull-up.
// Notes   : Slave stalls on request.
`timescale 1ns/100ps
// ==========================================================
// Board model
// ==========================================================
module reset_board (
    input  wire logic press_i,  // Supervisor pulls pin low
    input  wire logic pd_low_i, // Power-down capacitor empty
    input  wire logic slow_i,   // Slave stalls the cycle
    input  wire logic drv_n_i,  // Device drive value
    input  wire logic oe_i,     // Device pull-down enable
    output wire logic pin_n_o,  // Resolved reset pin
    output wire logic pd_o,     // Power-down threshold level
    output wire logic ready_n_o // Ready pin
);
    // pulse from supervisor
    // Wired-AND with pull-up
    assign pin_n_o   = !press_i && !(oe_i && !drv_n_i);
    assign pd_o      = !pd_low_i;
    assign ready_n_o = slow_i;
endmodule // reset_board

/* File: verification/reset_sequencer_test.sv */
// Purpose : Bench for the reset sequencer.
// Assumes : Board model resolves the pin.
// Notes   : Pulse lengths avoid the short/long limit.
`timescale 1ns/100ps
`include "reset_seq_defs.vh"
// ==========================================================
// Bench
// ==========================================================
module reset_sequencer_test;
    logic        clk, rst_n, press, pd_low, slow, sw, wdt, end_of_init_instr, wr;
    logic        act, uses, wdone, byp, pin_n, pd, rdy_n, drv_n, oe;
    logic        rout_n, ab, start, am, bi_o, seen_oe, seen_ab;
    logic [15:0] cfg, wdata, boot, exp_cfg;
    logic [23:0] addr;
    logic [1:0]  kind, exp_kind;
    int          fail_count, compares, i, n;

    reset_board board (.press_i(press), .pd_low_i(pd_low), .slow_i(slow),
        .drv_n_i(drv_n), .oe_i(oe), .pin_n_o(pin_n), .pd_o(pd),
        .ready_n_o(rdy_n));
    reset_sequencer dut (.CORE_CLK_I(clk), .RST_N_I(rst_n),
        .RESET_IN_N_I(pin_n), .POWERDOWN_LEVEL_I(pd), .READY_N_I(rdy_n),
        .BOOT_CONFIG_I(cfg), .SW_RESET_I(sw), .WDT_OVERFLOW_I(wdt),
        .END_INIT_I(end_of_init_instr), .SYSCFG_WR_I(wr), .SYSCFG_DATA_I(wdata),
        .BUS_ACTIVE_I(act), .BUS_USES_READY_I(uses),
        .BUS_WAITS_DONE_I(wdone), .PLL_BYPASS_I(byp),
        .RESET_OUT_N_O(rout_n), .RESET_IN_N_O(drv_n),
        .RESET_IN_N_OE_O(oe), .BUS_TRISTATE_O(), .CFG_PULLUP_O(),
        .HOLD_CANCEL_O(), .BUS_ABORT_O(ab), .STROBE_IDLE_O(),
        .CPU_START_O(start), .START_ADDR_O(addr), .BOOT_CFG_O(boot),
        .RESET_KIND_O(kind), .ASYNC_MODE_O(am), .BIDIR_ENABLE_O(bi_o));
    // Core clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Sticky flags, sampled settled
    always @(negedge clk) begin
        seen_oe = seen_oe | oe;
        seen_ab = seen_ab | ab;
    end
    task automatic check(input string what, input logic [23:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task tick(input int k);
        repeat (k) @(posedge clk);
    endtask
    task results;
        if (fail_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Expected config by reset kind
    function automatic logic [15:0] cfg_exp(input logic [1:0] k,
        input logic [15:0] d, p);
        logic [15:0] m;
        m = (k == `KIND_LONG) ? `CFG_MASK_LONG :
            (k == `KIND_SHORT) ? `CFG_MASK_SHORT : `CFG_MASK_SOFT;
        return ((p & ~m) | (d & m)) & ((k == `KIND_SOFT) ?
            ~`CFG_CLR_SOFT : 16'hffff);
    endfunction
    task expect_start(input int src, input logic bid, drop);
        for (i = 0; i < 3000 && start !== 1'b1; i++)
            @(negedge clk);
        check("start seen", start, 1'b1);
        check("kind", kind, exp_kind);
        check("boot config", boot, exp_cfg);
        check("async mode", am, drop);
        check("start address", addr, 24'h000000);
        check("bidir bit", bi_o, 1'b0);
        check("pull-down seen", seen_oe, bid);
        if (src < 3)
            check("abort seen", seen_ab, 1'b1);
        @(posedge clk);
        pd_low <= 1'b0;
        slow   <= 1'b0;
    endtask
    // Src 0 pin, 1 soft, 2 wdt abort, 3 wdt finish
    task run_reset(input int src, len, input logic bid, drop);
        @(posedge clk);
        wr    <= 1'b1;
        wdata <= 16'($urandom) & 16'hfff7 | {12'h000, bid, 3'b000};
        act   <= (src > 1);
        uses  <= (src == 2);
        wdone <= 1'b1;
        slow  <= (src == 2);
        @(posedge clk);
        wr    <= 1'b0;
        end_of_init_instr <= 1'b1;
        @(posedge clk);
        end_of_init_instr <= 1'b0;
        tick(3);
        @(negedge clk);
        check("reset out", rout_n, 1'b1);
        check("bidir bit", bi_o, bid);
        @(posedge clk);
        press <= 1'b1;
        @(posedge clk);
        press <= 1'b0;
        tick(10);
        @(negedge clk);
        check("reset out", rout_n, 1'b1);
        @(posedge clk);
        cfg     <= 16'($urandom);
        byp     <= 1'($urandom);
        seen_oe  = 1'b0;
        seen_ab  = 1'b0;
        press   <= (src == 0);
        sw      <= (src == 1);
        wdt     <= (src > 1);
        @(posedge clk);
        sw  <= 1'b0;
        wdt <= 1'b0;
        if (drop) begin
            tick(len / 2);
            pd_low <= 1'b1;
        end
        tick(drop ? len - len / 2 : len);
        press    <= 1'b0;
        act      <= 1'b0;
        exp_kind  = src ? `KIND_SOFT :
            (len > 400 || drop) ? `KIND_LONG : `KIND_SHORT;
        exp_cfg   = cfg_exp(exp_kind, cfg, exp_cfg);
        expect_start(src, bid, drop);
    endtask
    // Main sequence
    initial begin
        {rst_n, slow, sw, wdt, end_of_init_instr, wr, act, uses, wdone, byp} = '0;
        press      = 1'b1;
        pd_low     = 1'b1;
        wdata      = 16'h0000;
        fail_count = 0;
        compares   = 0;
        n          = $urandom(32'h8187143f);
        cfg        = 16'($urandom);
        seen_oe    = 1'b0;
        tick(12);
        rst_n <= 1'b1;
        tick(20);
        press   <= 1'b0;
        exp_kind = `KIND_LONG;
        exp_cfg  = cfg;
        expect_start(3, 1'b0, 1'b1);
        run_reset(1, 1, 1'b0, 1'b0);
        run_reset(2, 12, 1'b0, 1'b0);
        run_reset(3, 8, 1'b0, 1'b0);
        run_reset(0, 700, 1'b1, 1'b1);
        run_reset(0, 4, 1'b1, 1'b0);
        for (n = 0; n < 8; n++)
            run_reset(0, (n % 2) ? 600 + int'($urandom % 300) :
                4 + int'($urandom % 396), 1'($urandom), 1'b0);
        results;
    end
    // Hang guard
    initial begin
        tick(40000);
        fail_count++;
        results;
    end
endmodule // reset_sequencer_test
